/* File: tppio_pkg.sv */
// package for the triple port parallel io block: offsets, fields, reset values, carriers
// assumes a byte-wide host register port with 3-bit offsets, one clock
package tppio_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] TPPIO_OFS_FIRST  = 3'h0;
    localparam logic [2:0] TPPIO_OFS_SECOND = 3'h1;
    localparam logic [2:0] TPPIO_OFS_THIRD  = 3'h2;
    localparam logic [2:0] TPPIO_OFS_CTRL   = 3'h3;
    localparam logic [2:0] TPPIO_OFS_IRQCFG = 3'h4;
    localparam logic [2:0] TPPIO_OFS_IRQ_PENDING_FLAG  = 3'h5;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int TPPIO_CW_KIND_POS   = 7;
    localparam int TPPIO_CW_FIRST_POS  = 4;
    localparam int TPPIO_CW_TUPPER_POS = 3;
    localparam int TPPIO_CW_SECOND_POS = 1;
    localparam int TPPIO_CW_TLOWER_POS = 0;
    localparam int TPPIO_CW_BSEL_HI    = 3;
    localparam int TPPIO_CW_BSEL_LO    = 1;
    localparam int TPPIO_CW_BVAL_POS   = 0;

    // ------------------------------------------------------------
    // interrupt configuration, status and source fields
    // ------------------------------------------------------------
    localparam int TPPIO_IC_EN_POS   = 2;
    localparam int TPPIO_IC_MODE_HI  = 1;
    localparam int TPPIO_IC_MODE_LO  = 0;
    localparam int TPPIO_IS_PEND_POS = 0;
    localparam int TPPIO_IRQ_SRC_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       TPPIO_DIR_RST  = 1'b1;
    localparam logic       TPPIO_IEN_RST  = 1'b0;
    localparam logic [1:0] TPPIO_MODE_RST = 2'h0;
    localparam logic [7:0] TPPIO_OUT_RST  = 8'h00;

    typedef enum logic [1:0] {
        TPPIO_LOW_LEVEL  = 2'b00,
        TPPIO_HIGH_LEVEL = 2'b01,
        TPPIO_FALL_EDGE  = 2'b10,
        TPPIO_RISE_EDGE  = 2'b11
    } tppio_mode_e;

    // host access carrier
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } tppio_req_s;

    // direction set, one means input
    typedef struct packed {
        logic first_in;
        logic second_in;
        logic tupper_in;
        logic tlower_in;
    } tppio_dir_s;

endpackage

/* File: tppio_lane.sv */
// one 8-bit port lane: output register, enable, read-back mux
// assumes writes arrive as one-cycle strobes with their data on the same clock
`timescale 1ns/10ps
module tppio_lane
    import tppio_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] in_mask,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] out_r,
    output logic      [W-1:0] oe_r,
    output logic      [W-1:0] rdval
);
    // elaboration-time refusal of a lane the logic cannot serve
    if (W < 1) begin : g_bad_width
        $error("lane width must be positive");
    end

    // register kept regardless of direction, so presets survive
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            out_r <= W'(TPPIO_OUT_RST);
        end else if (wr) begin
            out_r <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            oe_r <= '0;
        end else begin
            oe_r <= ~in_mask;
        end
    end

    // input bits show the pins, output bits show the driven value
    assign rdval = (pin_in & in_mask) | (out_r & ~in_mask);

endmodule // tppio_lane

/* File: tppio_top.sv */
// triple port parallel io: host byte registers, three 8-bit ports, port-one bit-0 interrupt
// assumes host strobes synchronous to ref_clk; pin pull-ups sit outside on the board
//
// Behaviour
// - six byte registers at offsets 0 to 5
// - input pin level reads as its bit
// - undriven input reads one via pull-up
// - output ports read back driven value
// - output register holds writes in any direction
// - stored one drives high, zero low
// - single third-port bit set or clear
// - kind zero: bits 3..1 select, bit0 value
// - directions come from write-only control word
// - kind one: bits 4,1,3,0 set directions
// - interrupt source is first port bit 0
// - irq setup: enable bit2, mode bits1..0
// - mode codes low high fall rise
// - status bit0 pending, read clears it
// - third port one byte, split nibbles
// - split read mixes pins and driven
// - split write updates both output halves
`timescale 1ns/10ps
module tppio_top
    import tppio_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire tppio_req_s  host_req,
    output logic      [7:0]  host_rdata_r,
    output logic             irq_r,
    input  wire logic [7:0]  first_port_in,
    output logic      [7:0]  first_port_out,
    output logic      [7:0]  first_port_oe,
    input  wire logic [7:0]  second_port_in,
    output logic      [7:0]  second_port_out,
    output logic      [7:0]  second_port_oe,
    input  wire logic [7:0]  third_port_in,
    output logic      [7:0]  third_port_out,
    output logic      [7:0]  third_port_oe
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic       wr_first;
    logic       wr_second;
    logic       wr_third;
    logic       wr_ctrl;
    logic       wr_icfg;
    logic       rd_ist;
    logic       word_kind_select;
    logic [2:0] bit_sel;
    logic [7:0] bit_mask;

    assign wr_first  = host_req.wr && host_req.addr == TPPIO_OFS_FIRST;
    assign wr_second = host_req.wr && host_req.addr == TPPIO_OFS_SECOND;
    assign wr_ctrl   = host_req.wr && host_req.addr == TPPIO_OFS_CTRL;
    assign wr_icfg   = host_req.wr && host_req.addr == TPPIO_OFS_IRQCFG;
    assign rd_ist    = host_req.rd && host_req.addr == TPPIO_OFS_IRQ_PENDING_FLAG;
    assign word_kind_select = host_req.wdata[TPPIO_CW_KIND_POS];
    assign bit_sel  = host_req.wdata[TPPIO_CW_BSEL_HI:TPPIO_CW_BSEL_LO];
    assign bit_mask = 8'h01 << bit_sel;

    // ------------------------------------------------------------
    // direction word
    // ------------------------------------------------------------
    tppio_dir_s dir_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dir_r <= {4{TPPIO_DIR_RST}};
        end else if (wr_ctrl && word_kind_select) begin
            dir_r.first_in  <= host_req.wdata[TPPIO_CW_FIRST_POS];
            dir_r.second_in <= host_req.wdata[TPPIO_CW_SECOND_POS];
            dir_r.tupper_in <= host_req.wdata[TPPIO_CW_TUPPER_POS];
            dir_r.tlower_in <= host_req.wdata[TPPIO_CW_TLOWER_POS];
        end
    end

    // third port takes a full byte or a single-bit update
    logic       third_wr;
    logic [7:0] third_wdata;
    logic [7:0] third_out;

    assign wr_third = host_req.wr && host_req.addr == TPPIO_OFS_THIRD;
    assign third_wr = wr_third || (wr_ctrl && !word_kind_select);
    always_comb begin
        if (wr_third) begin
            third_wdata = host_req.wdata;
        end else if (host_req.wdata[TPPIO_CW_BVAL_POS]) begin
            third_wdata = third_out | bit_mask;
        end else begin
            third_wdata = third_out & ~bit_mask;
        end
    end

    // ------------------------------------------------------------
    // port lanes
    // ------------------------------------------------------------
    logic [7:0] first_rd;
    logic [7:0] second_rd;
    logic [7:0] third_rd;
    logic [7:0] third_mask;

    assign third_mask = {{4{dir_r.tupper_in}}, {4{dir_r.tlower_in}}};

    tppio_lane #(.W(8)) u_first (
        .ref_clk (ref_clk),
        .srst    (srst),
        .wr      (wr_first),
        .wdata   (host_req.wdata),
        .in_mask ({8{dir_r.first_in}}),
        .pin_in  (first_port_in),
        .out_r   (first_port_out),
        .oe_r    (first_port_oe),
        .rdval   (first_rd)
    );

    tppio_lane #(.W(8)) u_second (
        .ref_clk (ref_clk),
        .srst    (srst),
        .wr      (wr_second),
        .wdata   (host_req.wdata),
        .in_mask ({8{dir_r.second_in}}),
        .pin_in  (second_port_in),
        .out_r   (second_port_out),
        .oe_r    (second_port_oe),
        .rdval   (second_rd)
    );

    tppio_lane #(.W(8)) u_third (
        .ref_clk (ref_clk),
        .srst    (srst),
        .wr      (third_wr),
        .wdata   (third_wdata),
        .in_mask (third_mask),
        .pin_in  (third_port_in),
        .out_r   (third_out),
        .oe_r    (third_port_oe),
        .rdval   (third_rd)
    );

    assign third_port_out = third_out;

    // ------------------------------------------------------------
    // interrupt setup and detection
    // ------------------------------------------------------------
    logic        irq_en_r;
    tppio_mode_e irq_mode_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_en_r   <= TPPIO_IEN_RST;
            irq_mode_r <= tppio_mode_e'(TPPIO_MODE_RST);
        end else if (wr_icfg) begin
            irq_en_r   <= host_req.wdata[TPPIO_IC_EN_POS];
            irq_mode_r <= tppio_mode_e'(host_req.wdata[TPPIO_IC_MODE_HI:TPPIO_IC_MODE_LO]);
        end
    end

    // the source is read back like any bit, so undriven reads one via the board pull-up
    logic src_now;
    logic src_s1_r;
    logic src_s2_r;
    logic src_s3_r;
    logic hit;
    logic pend_r;

    assign src_now = first_rd[TPPIO_IRQ_SRC_BIT];

    // two stages before any decision, a third for the edge compare
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            src_s1_r <= 1'b1;
            src_s2_r <= 1'b1;
            src_s3_r <= 1'b1;
        end else begin
            src_s1_r <= src_now;
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
        end
    end

    always_comb begin
        case (irq_mode_r)
            TPPIO_LOW_LEVEL:  hit = !src_s2_r;
            TPPIO_HIGH_LEVEL: hit = src_s2_r;
            TPPIO_FALL_EDGE:  hit = src_s3_r && !src_s2_r;
            TPPIO_RISE_EDGE:  hit = !src_s3_r && src_s2_r;
            default:          hit = 1'b0;
        endcase
    end

    // set wins over the read clear so no event is dropped
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pend_r <= 1'b0;
        end else if (irq_en_r && hit) begin
            pend_r <= 1'b1;
        end else if (rd_ist) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= pend_r && irq_en_r;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            host_rdata_r <= 8'h00;
        end else if (host_req.rd) begin
            case (host_req.addr)
                TPPIO_OFS_FIRST:  host_rdata_r <= first_rd;
                TPPIO_OFS_SECOND: host_rdata_r <= second_rd;
                TPPIO_OFS_THIRD:  host_rdata_r <= third_rd;
                TPPIO_OFS_IRQCFG: host_rdata_r <= {5'h00, irq_en_r, irq_mode_r};
                TPPIO_OFS_IRQ_PENDING_FLAG:  host_rdata_r <= {7'h00, pend_r};
                default:          host_rdata_r <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence ctrl_dir_write;
        wr_ctrl && word_kind_select;
    endsequence

    dir_update_a: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl_dir_write |=> dir_r.first_in == $past(host_req.wdata[4])
                           && dir_r.tlower_in == $past(host_req.wdata[0]))
        else $error("direction word not taken");

    bit_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        wr_ctrl && !word_kind_select && host_req.wdata[0] |=> third_out[$past(bit_sel)])
        else $error("bit set failed");

    bit_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        wr_ctrl && !word_kind_select && !host_req.wdata[0]
        |=> !third_out[$past(bit_sel)] && (third_out | $past(bit_mask)) == ($past(third_out) | $past(bit_mask)))
        else $error("bit clear failed or touched others");

    hold_out_a: assert property (@(posedge ref_clk) disable iff (srst)
        !wr_first |=> first_port_out == $past(first_port_out))
        else $error("first output register changed without write");

    oe_follow_a: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl_dir_write ##1 1'b1 |=> first_port_oe == {8{!$past(dir_r.first_in)}})
        else $error("enable does not follow direction");

    split_read_a: assert property (@(posedge ref_clk) disable iff (srst)
        host_req.rd && host_req.addr == TPPIO_OFS_THIRD
        |=> host_rdata_r == ($past(third_port_in & third_mask) | $past(third_out & ~third_mask)))
        else $error("third port read mix wrong");

    stat_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        rd_ist && !(irq_en_r && hit) |=> !pend_r)
        else $error("status read did not clear pending");

    rise_pend_a: assert property (@(posedge ref_clk) disable iff (srst)
        irq_en_r && irq_mode_r == TPPIO_RISE_EDGE && !src_s3_r && src_s2_r |=> pend_r)
        else $error("rising edge missed");

    irq_out_a: assert property (@(posedge ref_clk) disable iff (srst)
        pend_r && irq_en_r |=> irq_r)
        else $error("irq not raised");

    cfg_read_a: assert property (@(posedge ref_clk) disable iff (srst)
        host_req.rd && host_req.addr == TPPIO_OFS_IRQCFG |=> host_rdata_r[7:3] == 5'h00)
        else $error("config upper bits not zero");

    sequence src_fall;
        src_s3_r && !src_s2_r;
    endsequence

    fall_pend_a: assert property (@(posedge ref_clk) disable iff (srst)
        (irq_en_r && irq_mode_r == TPPIO_FALL_EDGE) ##0 src_fall |=> pend_r)
        else $error("falling edge missed");

    low_pend_a: assert property (@(posedge ref_clk) disable iff (srst)
        irq_en_r && irq_mode_r == TPPIO_LOW_LEVEL && !src_s2_r |=> pend_r)
        else $error("low level missed");

    dis_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        !irq_en_r && !pend_r |=> !pend_r)
        else $error("pending set while disabled");

    st_read_a: assert property (@(posedge ref_clk) disable iff (srst)
        rd_ist |=> host_rdata_r == {7'h00, $past(pend_r)})
        else $error("status read wrong");

    unmap_read_a: assert property (@(posedge ref_clk) disable iff (srst)
        host_req.rd && host_req.addr > TPPIO_OFS_IRQ_PENDING_FLAG |=> host_rdata_r == 8'h00)
        else $error("unmapped read not zero");

    third_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        wr_third |=> third_out == $past(host_req.wdata))
        else $error("third port write lost");

endmodule // tppio_top

/* File: tppio_host_bfm.sv */
// host processor model for the triple port parallel io block: byte reads and writes
// assumes the block samples requests on the rising edge of ref_clk
`timescale 1ns/10ps
module tppio_host_bfm
    import tppio_pkg::*;
(
    input  wire logic       ref_clk,
    output tppio_req_s      host_req,
    input  wire logic [7:0] host_rdata_r
);

    initial host_req = '0;

    // ------------------------------------------------------------
    // one access
    // ------------------------------------------------------------
    // raised after a falling edge and held across the taking edge;
    // idle bus shows inverted values so stale data cannot pass
    task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge ref_clk);
        host_req.rd    = rd;
        host_req.wr    = ~rd;
        host_req.addr  = a;
        host_req.wdata = d;
        @(negedge ref_clk);
        q              = host_rdata_r;
        host_req.rd    = 1'b0;
        host_req.wr    = 1'b0;
        host_req.addr  = ~a;
        host_req.wdata = ~d;
    endtask

endmodule // tppio_host_bfm

/* File: tppio_top_tb.sv */
// self-checking bench for tppio_top: register tests through the host model
// assumes field lines with pull-ups, modelled here from drive enables
`timescale 1ns/10ps
module tppio_top_tb
    import tppio_pkg::*;
;
    logic            ref_clk;
    logic            srst;
    tppio_req_s      host_req;
    logic      [7:0] rdata;
    logic            irq_r;
    wire logic [7:0] pin [3];
    wire logic [7:0] out [3];
    wire logic [7:0] oe [3];
    logic      [7:0] ext [3];
    logic      [7:0] drv [3];
    logic      [7:0] q;
    logic      [7:0] e;
    int              n_errors = 0;
    int              n_tests = 0;

    // undriven lines float to one through the pull-ups
    for (genvar k = 0; k < 3; k++) begin : g_pin
        assign pin[k] = (oe[k] & out[k]) | (~oe[k] & ((drv[k] & ext[k]) | ~drv[k]));
    end

    tppio_host_bfm bfm (.ref_clk(ref_clk), .host_req(host_req), .host_rdata_r(rdata));

    tppio_top dut (
        .ref_clk(ref_clk), .srst(srst), .host_req(host_req), .host_rdata_r(rdata),
        .irq_r(irq_r),
        .first_port_in(pin[0]), .first_port_out(out[0]), .first_port_oe(oe[0]),
        .second_port_in(pin[1]), .second_port_out(out[1]), .second_port_oe(oe[1]),
        .third_port_in(pin[2]), .third_port_out(out[2]), .third_port_oe(oe[2])
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bfm.access(1'b0, a, d, q);
    endtask

    task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] x);
        bfm.access(1'b1, a, 8'h00, q);
        chk(nm, x, q);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // whole run is a few hundred cycles
    initial begin
        #400000;
        n_errors++;
        end_sim;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        ext  = '{default: 8'h00};
        drv  = '{default: 8'h00};
        cyc(2);
        srst = 1'b0;
        cyc(1);
        chk("oe_rst", 8'h00, oe[0]);
        rdc("cfg_rst", 3'h4, 8'h00);
        rdc("st_rst", 3'h5, 8'h00);
        rdc("ctl_rd", 3'h3, 8'h00);
        wr(3'h6, 8'hFF);
        rdc("unmap", 3'h6, 8'h00);
        wr(3'h5, 8'hFF);
        rdc("st_ro", 3'h5, 8'h00);
        rdc("undrv", 3'h1, 8'hFF);
        drv[0] = 8'hFF;
        ext[0] = 8'hA5;
        cyc(3);
        rdc("pin_rd", 3'h0, 8'hA5);
        // preset while input, then enable
        wr(3'h0, 8'h3C);
        cyc(2);
        chk("pre_out", 8'h3C, out[0]);
        chk("pre_oe", 8'h00, oe[0]);
        wr(3'h3, 8'h8B);
        cyc(2);
        chk("a_oe", 8'hFF, oe[0]);
        chk("a_pin", 8'h3C, pin[0]);
        rdc("a_rd", 3'h0, 8'h3C);
        wr(3'h3, 8'h9B);
        cyc(2);
        chk("keep", 8'h3C, out[0]);
        // all sixteen direction words, ignored bits set
        for (int i = 0; i < 16; i++) begin
            wr(3'h3, 8'hE4 | {3'h0, i[3], i[2], 1'b0, i[1], i[0]});
            cyc(2);
            chk("oe_a", {8{~i[3]}}, oe[0]);
            chk("oe_b", {8{~i[1]}}, oe[1]);
            chk("oe_c", {{4{~i[2]}}, {4{~i[0]}}}, oe[2]);
        end
        // set bits 0..7 one by one, then clear them
        wr(3'h2, 8'h00);
        for (int b = 0; b < 16; b++) begin
            wr(3'h3, {4'h7, b[2:0], ~b[3]});
            e = (b < 8) ? (8'hFF >> (7 - b)) : (8'hFF << (b - 7));
            chk("bsr", e, out[2]);
        end
        // second port: written while input, then driven and read back
        wr(3'h1, 8'h96);
        chk("b_out", 8'h96, out[1]);
        wr(3'h3, 8'h99);
        cyc(2);
        chk("b_pin", 8'h96, pin[1]);
        rdc("b_rd", 3'h1, 8'h96);
        // split third port: upper input, lower output
        drv[2] = 8'hFF;
        ext[2] = 8'h5A;
        wr(3'h3, 8'h9A);
        wr(3'h2, 8'hC3);
        cyc(2);
        chk("sp_out", 8'hC3, out[2]);
        chk("sp_oe", 8'h0F, oe[2]);
        rdc("sp_rd", 3'h2, 8'h53);
        // a neighbour bit must not trigger
        ext[0] = 8'h00;
        wr(3'h4, 8'h07);
        ext[0] = 8'h02;
        cyc(4);
        ext[0] = 8'h00;
        cyc(4);
        rdc("src", 3'h5, 8'h00);
        for (int m = 0; m < 4; m++) begin
            ext[0] = {7'h0, ~m[0]};
            cyc(4);
            wr(3'h4, 8'hFC | m[7:0]);
            rdc("cfg", 3'h4, 8'h04 | m[7:0]);
            cyc(3);
            bfm.access(1'b1, 3'h5, 8'h00, q);
            cyc(3);
            ext[0][0] = m[0];
            cyc(6);
            chk("irq", 8'h01, {7'h0, irq_r});
            ext[0][0] = ~m[0];
            cyc(4);
            rdc("pend", 3'h5, 8'h01);
            cyc(3);
            chk("irq_off", 8'h00, {7'h0, irq_r});
            rdc("clr", 3'h5, 8'h00);
        end
        // disabled rising mode stays quiet
        wr(3'h4, 8'h03);
        ext[0] = 8'h01;
        cyc(6);
        chk("irq_dis", 8'h00, {7'h0, irq_r});
        rdc("st_dis", 3'h5, 8'h00);
        // mid-run reset with all ports driving and a config loaded
        wr(3'h3, 8'h80);
        cyc(2);
        chk("oe_all", 8'hFF, oe[2]);
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        cyc(1);
        chk("oe_rst2", 8'h00, oe[2]);
        chk("oe_rst3", 8'h00, oe[0]);
        rdc("cfg_rst2", 3'h4, 8'h00);
        rdc("st_rst2", 3'h5, 8'h00);
        end_sim;
    end

endmodule // tppio_top_tb
